// File: sim/msb_motor_model.sv
`timescale 1ns/10ps
module msb_motor_model (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Device side
    input  wire msb_pkg::msb_fire_type fire_q,
    input  wire logic                  stop_busy,
    // Bench side
    input  wire logic                  slow,
    input  wire logic [6:0]            speed_set,
    // Motor side
    output logic                       takeover_ok,
    output logic [6:0]                 speed
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [6:0] spd_q;
    logic [6:0] spd_d;
    // ----------------------------------
    // Stage and shaft
    // ----------------------------------
    // Speed rises at once but runs down one step a cycle, like a loaded shaft
    // Current moves to the stage only while a stop is busy and a phase fires
    always_comb begin
        cnt_d = (stop_busy && fire_q.fire != 3'h0) ? cnt_q + {4'h0, cnt_q != 5'h1f} : 5'h00;
        spd_d = (speed_set > spd_q) ? speed_set : spd_q - {6'h0, speed_set < spd_q};
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= 5'h00;
            spd_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
            spd_q <= spd_d;
        end
    end
    // current takeover
    // Slow stage needs 20 cycles, still inside the fallback
    assign takeover_ok = cnt_q >= (slow ? 5'h14 : 5'h03);
    assign speed       = spd_q;
endmodule : msb_motor_model

// File: sim/msb_sequencer_checker.sv
`timescale 1ns/10ps
module msb_sequencer_checker (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // Settings and commands
    input wire msb_pkg::msb_cfg_type  cfg,
    input wire logic                  cfg_load,
    input wire logic                  run_cmd,
    input wire logic                  stop_cmd,
    input wire logic                  allow_fwd,
    input wire logic                  allow_rev,
    input wire logic [6:0]            speed,
    // Device outputs
    input wire logic                  run_contactor,
    input wire logic                  brake_contactor,
    input wire msb_pkg::msb_fire_type fire_q,
    input wire logic                  run_internal,
    input wire logic                  stop_busy,
    input wire msb_pkg::msb_cfg_type  cfg_q
);
    // ----------------------------------
    // Properties
    // ----------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    AST_RST_DEFAULTS: assert property ($fell(reset) |->
        cfg_q.stop_method == 3'h4 && cfg_q.dc_speed == 7'h1e && cfg_q.stop_time == 11'h064)
        else $error("settings not at defaults after reset");
    AST_CODE_IGNORED: assert property (
        cfg_load && (cfg.stop_method == 3'h0 || cfg.stop_method > 3'h5)
        |=> $stable(cfg_q.stop_method))
        else $error("invalid stop code was accepted");
    AST_PCT_CLIP: assert property (cfg_load && cfg.dc_speed > 7'h64
        |=> cfg_q.dc_speed == 7'h64)
        else $error("switch-over speed not clipped");
    AST_CONTACT_EXCL: assert property (brake_contactor |-> !run_contactor)
        else $error("both contactors energised");
    AST_RUN_INT: assert property (run_cmd |=> run_internal)
        else $error("internal run missing");
    AST_JOG_REFUSE: assert property (!run_cmd && !allow_fwd && !allow_rev
        |=> !run_internal)
        else $error("jog accepted with no direction allowed");
    AST_STOP_TAKE: assert property (
        run_contactor && !run_internal && stop_cmd && !stop_busy |=> stop_busy)
        else $error("stop command not taken");
    AST_DC_SWITCH: assert property (
        stop_busy && brake_contactor && speed != 7'h00 && speed < cfg_q.dc_speed
        |-> ##[1:4] fire_q.fire == 3'h6)
        else $error("no change to two-phase braking");
    AST_DC_HOLD: assert property (fire_q.fire == 3'h6
        |=> fire_q.fire == 3'h6 || fire_q.fire == 3'h0)
        else $error("third phase fired during two-phase braking");
    AST_DC_END: assert property (
        stop_busy && fire_q.fire == 3'h6 && speed == 7'h00 |=> fire_q.fire == 3'h0)
        else $error("two-phase braking kept at standstill");
endmodule : msb_sequencer_checker

// File: sim/tb_msb_sequencer.sv
`timescale 1ns/10ps
module tb_msb_sequencer;
    logic                  mclk, reset, cfg_load, run_cmd, stop_cmd, takeover_ok, slow;
    logic                  jk_f, jk_r, ji_f, ji_r, jc_f, jc_r, jm_f, jm_r, al_f, al_r;
    logic                  rs_en, rs_stop, run_contactor, brake_contactor, run_internal;
    logic                  jog_dir_rev, stop_busy;
    logic [6:0]            speed, speed_set, brake_strength, jog_speed;
    logic [9:0]            jog_pat [7] = '{10'h282, 10'h00a, 10'h0a2, 10'h082, 10'h201,
                                           10'h101, 10'h053};
    logic [8:0]            jog_exp [7] = '{9'h10a, 9'h10a, 9'h10a, 9'h000, 9'h000,
                                           9'h194, 9'h194};
    msb_pkg::msb_cfg_type  cfg, cfg_q;
    msb_pkg::msb_fire_type fire_q;
    int                    err_total = 0;
    int                    tests_run = 0;

    always #20 mclk = ~mclk;

    msb_sequencer u_dut (.mclk(mclk), .reset(reset), .cfg(cfg), .cfg_load(cfg_load),
        .run_cmd(run_cmd), .stop_cmd(stop_cmd), .takeover_ok(takeover_ok),
        .jog_key_fwd(jk_f), .jog_key_rev(jk_r), .jog_forward_input(ji_f),
        .jog_reverse_input(ji_r), .jog_di_fwd_cfg(jc_f), .jog_di_rev_cfg(jc_r),
        .jog_com_fwd(jm_f), .jog_com_rev(jm_r), .allow_fwd(al_f), .allow_rev(al_r),
        .speed(speed), .torque_now(7'h32), .rot_sensor_en(rs_en),
        .rot_sensor_stop(rs_stop), .run_contactor(run_contactor),
        .brake_contactor(brake_contactor), .fire_q(fire_q), .brake_strength(brake_strength),
        .run_internal(run_internal), .jog_dir_rev(jog_dir_rev), .jog_speed(jog_speed),
        .stop_busy(stop_busy), .cfg_q(cfg_q));
    msb_motor_model u_motor (.mclk(mclk), .reset(reset), .fire_q(fire_q),
        .stop_busy(stop_busy), .slow(slow),
        .speed_set(speed_set), .takeover_ok(takeover_ok), .speed(speed));

    // ----------------------------------
    // Access tasks
    // ----------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Long stop time so only standstill or the sensor ends braking
    task automatic set_cfg(input logic [2:0] m, input logic b, input logic [6:0] dcs);
        cfg = '{m, b, 7'h00, 7'h3c, dcs, 7'h4b, 7'h0f, 11'h4b0, 11'h000, 7'h0a, 7'h14};
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
        tick(1);
    endtask : set_cfg
    task automatic wait_fire(input logic [2:0] f);
        for (int i = 0; i < 200 && fire_q.fire !== f; i++) tick(1);
        chk(fire_q.fire, f);
    endtask : wait_fire
    task automatic run_then_stop(input logic [6:0] spd);
        speed_set = spd;
        run_cmd = 1'b1;
        tick(4);
        chk(run_contactor, 1'b1);
        run_cmd = 1'b0;
        tick(2);
        stop_cmd = 1'b1;
        tick(1);
        stop_cmd = 1'b0;
        tick(1);
        chk(stop_busy, 1'b1);
    endtask : run_then_stop
    task automatic end_stop();
        for (int i = 0; i < 200 && stop_busy !== 1'b0; i++) tick(1);
        chk(stop_busy, 1'b0);
        chk(brake_contactor, 1'b0);
    endtask : end_stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------
    // Tests
    // ----------------------------------
    initial begin
        {mclk, cfg_load, run_cmd, stop_cmd, slow, rs_en, rs_stop} = 7'h00;
        {jk_f, jk_r, ji_f, ji_r, jc_f, jc_r, jm_f, jm_r, al_f, al_r} = 10'h000;
        reset = 1'b1;
        speed_set = 7'h00;
        cfg = '0;
        tick(12);
        reset = 1'b0;
        tick(1);
        chk({cfg_q.stop_method, cfg_q.brake_method}, 4'h8);
        chk({cfg_q.end_torque, cfg_q.step_down}, 14'h0064);
        chk({cfg_q.dc_speed, cfg_q.vec_strength}, 14'h0f4b);
        chk({cfg_q.rcb_delay, cfg_q.dc_strength}, 18'h0028f);
        chk({cfg_q.stop_time, cfg_q.jog_speed_fwd}, 18'h0320a);
        for (int c = 1; c <= 5; c++) begin
            set_cfg(c[2:0], 1'b0, 7'h7f);
            chk(cfg_q.stop_method, c[2:0]);
        end
        chk(cfg_q.dc_speed, 7'h64);
        set_cfg(3'h7, 1'b1, 7'h1e);
        chk(cfg_q.stop_method, 3'h5);
        // Jog sources, direction and refusals, one row each
        for (int i = 0; i < 7; i++) begin
            {jk_f, jk_r, ji_f, ji_r, jc_f, jc_r, jm_f, jm_r, al_f, al_r} = jog_pat[i];
            tick(3);
            chk({run_internal, jog_exp[i][8] ? {jog_dir_rev, jog_speed} : 8'h00},
                jog_exp[i]);
            {jk_f, jk_r, ji_f, ji_r, jc_f, jc_r, jm_f, jm_r, al_f, al_r} = 10'h000;
            tick(3);
        end
        // Coast after a slow takeover
        set_cfg(3'h4, 1'b0, 7'h1e);
        slow = 1'b1;
        run_then_stop(7'h50);
        chk(fire_q.fire, 3'h7);
        wait_fire(3'h0);
        end_stop();
        // Reverse-current braking
        slow = 1'b0;
        set_cfg(3'h5, 1'b1, 7'h1e);
        run_then_stop(7'h50);
        for (int i = 0; i < 50 && brake_contactor !== 1'b1; i++) tick(1);
        chk({brake_contactor, run_contactor}, 2'h2);
        tick(5);
        chk(fire_q.fire === 3'h6, 1'b0);
        speed_set = 7'h10;
        wait_fire(3'h6);
        chk(brake_strength, 7'h0f);
        speed_set = 7'h00;
        wait_fire(3'h0);
        end_stop();
        // Vector braking; a reload in mid-stop must not change the method
        set_cfg(3'h5, 1'b0, 7'h28);
        run_then_stop(7'h50);
        tick(10);
        chk({brake_contactor, brake_strength}, 8'h4b);
        set_cfg(3'h4, 1'b1, 7'h28);
        speed_set = 7'h20;
        wait_fire(3'h6);
        chk(brake_contactor, 1'b0);
        {rs_en, rs_stop} = 2'h3;
        wait_fire(3'h0);
        end_stop();
        // Linear-torque and voltage stops end only at timeout, so a mid-run reset cuts each short
        for (int m = 1; m <= 3; m += 2) begin
            set_cfg(m[2:0], 1'b0, 7'h1e);
            run_then_stop(7'h50);
            tick(6);
            chk({fire_q.torque_mode, fire_q.level}, (m == 1) ? 8'hb2 : 8'h3c);
            reset = 1'b1;
            tick(2);
            reset = 1'b0;
            tick(1);
            chk({cfg_q.stop_method, stop_busy, fire_q.fire, run_contactor}, 8'h80);
        end
        wrap_up();
    end

    initial begin
        #800000;
        err_total++;
        wrap_up();
    end
endmodule : tb_msb_sequencer

bind msb_sequencer msb_sequencer_checker u_chk (.mclk(mclk), .reset(reset), .cfg(cfg),
    .cfg_load(cfg_load), .run_cmd(run_cmd), .stop_cmd(stop_cmd), .allow_fwd(allow_fwd),
    .allow_rev(allow_rev), .speed(speed), .run_contactor(run_contactor),
    .brake_contactor(brake_contactor), .fire_q(fire_q), .run_internal(run_internal),
    .stop_busy(stop_busy), .cfg_q(cfg_q));

// File: src/msb_pkg.sv
package msb_pkg;
    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned TICK_HZ      = 1000;
    localparam int unsigned TICK_CYC     = CLK_HZ / TICK_HZ;
    // Time settings in tenths of seconds, the takeover fallback in clock cycles, the others in percent
    localparam logic [10:0] STOP_TIME_RST = 11'h064;
    localparam logic [10:0] RCB_DLY_RST   = 11'h005;
    localparam logic [10:0] TIME_MAX      = 11'h4b0;
    localparam logic [6:0]  PCT_MAX       = 7'h64;
    localparam logic [6:0]  END_TQ_RST    = 7'h00;
    localparam logic [6:0]  STEP_DN_RST   = 7'h64;
    localparam logic [6:0]  DC_SPD_RST    = 7'h1e;
    localparam logic [6:0]  VEC_STR_RST   = 7'h4b;
    localparam logic [6:0]  DC_STR_RST    = 7'h0f;
    localparam logic [6:0]  JOG_SPD_RST   = 7'h0a;
    localparam logic [6:0]  JOG_SPD_MAX   = 7'h1e;
    localparam logic [6:0]  STANDSTILL    = 7'h00;
    localparam logic [6:0]  MIN_ON        = 7'h00;
    localparam logic [7:0]  TAKEOVER_CYC  = 8'h19;
    localparam int unsigned SUB_W        = 12;

    typedef enum logic [2:0] {
        STOP_LIN_TQ = 3'h1,
        STOP_SQR_TQ = 3'h2,
        STOP_VOLT   = 3'h3,
        STOP_COAST  = 3'h4,
        STOP_BRAKE  = 3'h5
    } msb_stop_type;

    typedef enum logic {
        BRK_VECTOR  = 1'h0,
        BRK_REVERSE = 1'h1
    } msb_brake_type;

    typedef struct packed {
        logic [2:0]  stop_method;
        logic        brake_method;
        logic [6:0]  end_torque;
        logic [6:0]  step_down;
        logic [6:0]  dc_speed;
        logic [6:0]  vec_strength;
        logic [6:0]  dc_strength;
        logic [10:0] stop_time;
        logic [10:0] rcb_delay;
        logic [6:0]  jog_speed_fwd;
        logic [6:0]  jog_speed_rev;
    } msb_cfg_type;

    typedef struct packed {
        logic [2:0] fire;
        logic [6:0] level;
        logic       torque_mode;
    } msb_fire_type;
endpackage : msb_pkg

// File: src/msb_sequencer.sv
`timescale 1ns/10ps
module msb_sequencer (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // Settings
    input  wire msb_pkg::msb_cfg_type cfg,
    input  wire logic                 cfg_load,
    // Run and stop
    input  wire logic                 run_cmd,
    input  wire logic                 stop_cmd,
    input  wire logic                 takeover_ok,
    // Jog
    input  wire logic                 jog_key_fwd,
    input  wire logic                 jog_key_rev,
    input  wire logic                 jog_forward_input,
    input  wire logic                 jog_reverse_input,
    input  wire logic                 jog_di_fwd_cfg,
    input  wire logic                 jog_di_rev_cfg,
    input  wire logic                 jog_com_fwd,
    input  wire logic                 jog_com_rev,
    input  wire logic                 allow_fwd,
    input  wire logic                 allow_rev,
    // Motor feedback
    input  wire logic [6:0]           speed,
    input  wire logic [6:0]           torque_now,
    input  wire logic                 rot_sensor_en,
    input  wire logic                 rot_sensor_stop,
    // Outputs
    output logic                      run_contactor,
    output logic                      brake_contactor,
    output msb_pkg::msb_fire_type     fire_q,
    output logic [6:0]                brake_strength,
    output logic                      run_internal,
    output logic                      jog_dir_rev,
    output logic [6:0]                jog_speed,
    output logic                      stop_busy,
    output msb_pkg::msb_cfg_type      cfg_q
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum {S_IDLE, S_RUN, S_TAKEOVER, S_TQ, S_VOLT, S_VEC, S_RC_DLY,
                  S_RC, S_DC} msb_state_type;

    // Tenth-second tick; counter sized to hold the whole period
    localparam int unsigned TENTH_CYC = msb_pkg::TICK_CYC * 100;
    localparam int unsigned SUB_BITS  = $clog2(TENTH_CYC);

    msb_state_type          st_q, st_d;
    msb_pkg::msb_cfg_type   cfg_d;
    logic [2:0]             lat_stop_q, lat_stop_d;
    logic                   lat_brk_q, lat_brk_d;
    logic [6:0]             tq0_q, tq0_d;
    logic [10:0]            t_q, t_d;
    logic [10:0]            dly_q, dly_d;
    logic [7:0]             to_q, to_d;
    logic [SUB_BITS-1:0]    sub_q, sub_d;
    logic                   tick;
    msb_pkg::msb_fire_type  fire_d;
    logic                   k1_q, k1_d, k2_q, k2_d;
    logic [6:0]             str_q, str_d;
    logic                   run_q, run_d, jrev_q, jrev_d, busy_q, busy_d;
    logic [6:0]             jspd_q, jspd_d;
    logic                   jf, jr;

    // Scale percentage by the fraction num over den, such as elapsed or remaining stop time
    function automatic logic [6:0] scale(input logic [6:0] pct, input logic [10:0] num,
                                         input logic [10:0] den);
        logic [17:0] p;
        p = 18'(pct) * 18'(num);
        scale = (den == 11'h000) ? 7'h00 : 7'(p / 18'(den));
    endfunction : scale

    function automatic logic [6:0] clip(input logic [6:0] v, input logic [6:0] mx);
        clip = (v > mx) ? mx : v;
    endfunction : clip

    assign tick = (sub_q == SUB_BITS'(TENTH_CYC - 1));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [10:0] rem;
        logic [6:0]  frac;
        rem = 11'h000;
        frac = 7'h00;
        st_d = st_q;
        cfg_d = cfg_q;
        lat_stop_d = lat_stop_q;
        lat_brk_d = lat_brk_q;
        tq0_d = tq0_q;
        t_d = t_q;
        dly_d = dly_q;
        to_d = to_q;
        sub_d = tick ? '0 : sub_q + SUB_BITS'(1);
        fire_d = fire_q;
        k1_d = k1_q;
        k2_d = k2_q;
        str_d = str_q;
        jspd_d = 7'h00;
        jrev_d = jrev_q;
        // Settings clipped to their ranges on load; an invalid stop code keeps the old stop method
        if (cfg_load) begin
            cfg_d = cfg;
            cfg_d.end_torque = clip(cfg.end_torque, msb_pkg::PCT_MAX);
            cfg_d.step_down = clip(cfg.step_down, msb_pkg::PCT_MAX);
            cfg_d.dc_speed = clip(cfg.dc_speed, msb_pkg::PCT_MAX);
            cfg_d.vec_strength = clip(cfg.vec_strength, msb_pkg::PCT_MAX);
            cfg_d.dc_strength = clip(cfg.dc_strength, msb_pkg::PCT_MAX);
            cfg_d.stop_time = (cfg.stop_time > msb_pkg::TIME_MAX) ? msb_pkg::TIME_MAX
                                                                  : cfg.stop_time;
            cfg_d.rcb_delay = (cfg.rcb_delay > msb_pkg::TIME_MAX) ? msb_pkg::TIME_MAX
                                                                  : cfg.rcb_delay;
            cfg_d.jog_speed_fwd = clip(cfg.jog_speed_fwd, msb_pkg::JOG_SPD_MAX);
            cfg_d.jog_speed_rev = clip(cfg.jog_speed_rev, msb_pkg::JOG_SPD_MAX);
            if (cfg.stop_method < 3'(msb_pkg::STOP_LIN_TQ)
                    || cfg.stop_method > 3'(msb_pkg::STOP_BRAKE))
                cfg_d.stop_method = cfg_q.stop_method;
        end
        // three jog sources, digital input only if configured, direction allowed
        jf = allow_fwd && (jog_key_fwd || (jog_forward_input && jog_di_fwd_cfg) || jog_com_fwd);
        jr = allow_rev && (jog_key_rev || (jog_reverse_input && jog_di_rev_cfg) || jog_com_rev);
        if (jf && cfg_q.jog_speed_fwd != 7'h00) begin
            jspd_d = cfg_q.jog_speed_fwd;
            jrev_d = 1'b0;
        end else if (jr && cfg_q.jog_speed_rev != 7'h00) begin
            jspd_d = cfg_q.jog_speed_rev;
            jrev_d = 1'b1;
        end
        run_d = run_cmd || (jspd_d != 7'h00);
        // Stop timer in tenths
        if (tick && t_q != 11'h000)
            t_d = t_q - 11'h001;
        if (tick && dly_q != 11'h000)
            dly_d = dly_q - 11'h001;
        rem = cfg_q.stop_time - t_q;
        unique case (st_q)
            S_IDLE: begin
                fire_d = '0;
                k1_d = 1'b0;
                k2_d = 1'b0;
                if (run_d) begin
                    st_d = S_RUN;
                end
            end
            S_RUN: begin
                // run contactor during start and run
                k1_d = 1'b1;
                fire_d.fire = 3'h7;
                fire_d.level = msb_pkg::PCT_MAX;
                fire_d.torque_mode = 1'b0;
                if (stop_cmd && !run_d) begin
                    lat_stop_d = cfg_q.stop_method;
                    lat_brk_d = cfg_q.brake_method;
                    tq0_d = torque_now;
                    to_d = msb_pkg::TAKEOVER_CYC;
                    st_d = S_TAKEOVER;
                end
            end
            S_TAKEOVER: begin
                // thyristors take current before stop method
                fire_d.fire = 3'h7;
                to_d = (to_q != 8'h00) ? to_q - 8'h01 : to_q;
                if (takeover_ok || to_q == 8'h00) begin
                    t_d = cfg_q.stop_time;
                    unique case (lat_stop_q)
                        3'(msb_pkg::STOP_LIN_TQ), 3'(msb_pkg::STOP_SQR_TQ): st_d = S_TQ;
                        3'(msb_pkg::STOP_VOLT): begin
                            fire_d.level = cfg_q.step_down;
                            st_d = S_VOLT;
                        end
                        // brake method only for brake code
                        3'(msb_pkg::STOP_BRAKE): st_d = lat_brk_q ? S_RC_DLY : S_VEC;
                        default: st_d = S_IDLE;
                    endcase
                    if (lat_stop_q == 3'(msb_pkg::STOP_BRAKE) && lat_brk_q) begin
                        k1_d = 1'b0;
                        fire_d.fire = 3'h0;
                        dly_d = cfg_q.rcb_delay;
                    end
                    if (st_d == S_IDLE)
                        k1_d = 1'b0;
                end
            end
            S_TQ: begin
                // ramp from stop torque, to end torque
                fire_d.torque_mode = 1'b1;
                frac = scale(msb_pkg::PCT_MAX, rem, cfg_q.stop_time);
                if (lat_stop_q == 3'(msb_pkg::STOP_SQR_TQ))
                    frac = PCT_SQ(frac);
                if (tq0_q > cfg_q.end_torque)
                    fire_d.level = tq0_q - scale(tq0_q - cfg_q.end_torque, 11'(frac),
                                                 11'(msb_pkg::PCT_MAX));
                else
                    fire_d.level = cfg_q.end_torque;
            end
            S_VOLT: begin
                fire_d.level = msb_pkg::MIN_ON + scale(cfg_q.step_down, t_q, cfg_q.stop_time);
            end
            S_VEC: begin
                fire_d.fire = 3'h7;
                str_d = cfg_q.vec_strength;
                if (speed < cfg_q.dc_speed)
                    st_d = S_DC;
            end
            S_RC_DLY: begin
                if (dly_q == 11'h000) begin
                    k2_d = 1'b1;
                    st_d = S_RC;
                end
            end
            S_RC: begin
                fire_d.fire = 3'h7;
                str_d = cfg_q.vec_strength;
                if (speed < cfg_q.dc_speed)
                    st_d = S_DC;
            end
            S_DC: begin
                fire_d.fire = 3'h6;
                str_d = cfg_q.dc_strength;
                if (speed == msb_pkg::STANDSTILL || (rot_sensor_en && rot_sensor_stop))
                    st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
        if ((st_q == S_TQ || st_q == S_VOLT || st_q == S_VEC || st_q == S_RC_DLY
                || st_q == S_RC || st_q == S_DC) && t_q == 11'h000)
            st_d = S_IDLE;
        if (st_d == S_IDLE && st_q != S_IDLE) begin
            fire_d = '0;
            k1_d = 1'b0;
            k2_d = 1'b0;
            str_d = 7'h00;
        end
        busy_d = (st_d != S_IDLE) && (st_d != S_RUN);
    end

    function automatic logic [6:0] PCT_SQ(input logic [6:0] f);
        logic [13:0] p;
        p = 14'(f) * 14'(f);
        PCT_SQ = 7'(p / 14'(msb_pkg::PCT_MAX));
    endfunction : PCT_SQ

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= S_IDLE;
            cfg_q <= '{stop_method: 3'(msb_pkg::STOP_COAST), brake_method: 1'b0,
                       end_torque: msb_pkg::END_TQ_RST, step_down: msb_pkg::STEP_DN_RST,
                       dc_speed: msb_pkg::DC_SPD_RST, vec_strength: msb_pkg::VEC_STR_RST,
                       dc_strength: msb_pkg::DC_STR_RST, stop_time: msb_pkg::STOP_TIME_RST,
                       rcb_delay: msb_pkg::RCB_DLY_RST, jog_speed_fwd: msb_pkg::JOG_SPD_RST,
                       jog_speed_rev: msb_pkg::JOG_SPD_RST};
            lat_stop_q <= 3'(msb_pkg::STOP_COAST);
            lat_brk_q <= 1'b0;
            tq0_q <= 7'h00;
            t_q <= 11'h000;
            dly_q <= 11'h000;
            to_q <= 8'h00;
            sub_q <= '0;
            fire_q <= '0;
            k1_q <= 1'b0;
            k2_q <= 1'b0;
            str_q <= 7'h00;
            run_q <= 1'b0;
            jrev_q <= 1'b0;
            jspd_q <= 7'h00;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cfg_q <= cfg_d;
            lat_stop_q <= lat_stop_d;
            lat_brk_q <= lat_brk_d;
            tq0_q <= tq0_d;
            t_q <= t_d;
            dly_q <= dly_d;
            to_q <= to_d;
            sub_q <= sub_d;
            fire_q <= fire_d;
            k1_q <= k1_d;
            k2_q <= k2_d;
            str_q <= str_d;
            run_q <= run_d;
            jrev_q <= jrev_d;
            jspd_q <= jspd_d;
            busy_q <= busy_d;
        end
    end

    assign run_contactor = k1_q;
    assign brake_contactor = k2_q;
    assign brake_strength = str_q;
    assign run_internal = run_q;
    assign jog_dir_rev = jrev_q;
    assign jog_speed = jspd_q;
    assign stop_busy = busy_q;
endmodule : msb_sequencer
